// [include/zcbu_pkg.sv]
// shared constants and types for the zero-compare branch unit
package zcbu_pkg;
	// ---------------------------------------------------------------
	// instruction field layout
	// ---------------------------------------------------------------
	localparam int OPC_HI = 31;
	localparam int OPC_LO = 26;
	localparam int SRC_HI = 25;
	localparam int SRC_LO = 21;
	localparam int SEL_HI = 20;
	localparam int SEL_LO = 16;
	localparam int OFF_HI = 15;
	localparam int OFF_LO = 0;
	localparam int OFF_SHIFT = 2;
	localparam int INSN_W = 32;

	// ---------------------------------------------------------------
	// primary opcodes and register-immediate selectors
	// ---------------------------------------------------------------
	localparam logic [5:0] OPC_REG_IMM = 6'h01;
	localparam logic [5:0] OPC_NONPOS = 6'h06;
	localparam logic [5:0] OPC_POS = 6'h07;
	localparam logic [5:0] OPC_NONPOS_LIKELY = 6'h16;
	localparam logic [5:0] OPC_POS_LIKELY = 6'h17;
	localparam logic [4:0] SEL_NEG = 5'h00;
	localparam logic [4:0] SEL_NONNEG = 5'h01;
	localparam logic [4:0] SEL_NEG_LIKELY = 5'h02;
	localparam logic [4:0] SEL_NONNEG_LIKELY = 5'h03;
	localparam logic [4:0] SEL_NEG_LINK = 5'h10;
	localparam logic [4:0] SEL_NONNEG_LINK = 5'h11;
	localparam logic [4:0] SEL_NEG_LINK_LIKELY = 5'h12;
	localparam logic [4:0] SEL_NONNEG_LINK_LIKELY = 5'h13;
	localparam logic [4:0] SEL_ZERO = 5'h00;

	// ---------------------------------------------------------------
	// link register and address offsets
	// ---------------------------------------------------------------
	localparam logic [4:0] LINK_REG = 5'h1f;
	localparam int SLOT_OFFSET = 4;
	localparam int LINK_OFFSET = 8;
	localparam int XLEN = 64;

	// condition class of a decoded branch
	typedef enum logic [3:0] {
		ZCBU_COND_NEG = 4'b0001,
		ZCBU_COND_NONNEG = 4'b0010,
		ZCBU_COND_POS = 4'b0100,
		ZCBU_COND_NONPOS = 4'b1000
	} zcbu_cond_t;

	// decoded branch
	typedef struct packed {
		logic valid;
		logic likely;
		logic link;
		zcbu_cond_t cond;
	} zcbu_dec_t;

	// redirect request to fetch
	typedef struct packed {
		logic valid;
		logic [XLEN-1:0] target;
	} zcbu_redir_t;

	// link write to the register file
	typedef struct packed {
		logic valid;
		logic [4:0] index;
		logic [XLEN-1:0] data;
	} zcbu_wb_t;
endpackage

// [verilog/zcbu_decode.sv]
// instruction decoder for the compare-against-zero branch family
`timescale 1ns/1ps
`default_nettype none
module zcbu_decode (
	input wire logic [31:0] insn_i,
	output zcbu_pkg::zcbu_dec_t dec_o
);
	import zcbu_pkg::*;

	// -----------------------------------------------------------------
	// field extraction
	// -----------------------------------------------------------------
	wire logic [5:0] opc = insn_i[OPC_HI:OPC_LO];
	wire logic [4:0] sel = insn_i[SEL_HI:SEL_LO];
	wire logic is_register_immediate_group = (opc == OPC_REG_IMM);
	// second field must be zero for the positive/nonpositive forms
	wire logic sel_zero = (sel == SEL_ZERO);

	// one-hot form matches
	wire logic m_pos = (opc == OPC_POS) && sel_zero; // RQ11
	wire logic m_pos_l = (opc == OPC_POS_LIKELY) && sel_zero; // RQ11
	wire logic m_npos = (opc == OPC_NONPOS) && sel_zero; // RQ11
	wire logic m_npos_l = (opc == OPC_NONPOS_LIKELY) && sel_zero; // RQ11
	wire logic m_neg = is_register_immediate_group && (sel == SEL_NEG); // RQ11
	wire logic m_neg_l = is_register_immediate_group && (sel == SEL_NEG_LIKELY); // RQ11
	wire logic m_neg_k = is_register_immediate_group && (sel == SEL_NEG_LINK); // RQ11
	wire logic m_neg_kl = is_register_immediate_group && (sel == SEL_NEG_LINK_LIKELY); // RQ11
	wire logic m_nn = is_register_immediate_group && (sel == SEL_NONNEG); // RQ11
	wire logic m_nn_l = is_register_immediate_group && (sel == SEL_NONNEG_LIKELY); // RQ11
	wire logic m_nn_k = is_register_immediate_group && (sel == SEL_NONNEG_LINK); // RQ11
	wire logic m_nn_kl = is_register_immediate_group && (sel == SEL_NONNEG_LINK_LIKELY); // RQ11

	// -----------------------------------------------------------------
	// class grouping
	// -----------------------------------------------------------------
	wire logic any_neg = m_neg | m_neg_l | m_neg_k | m_neg_kl;
	wire logic any_nn = m_nn | m_nn_l | m_nn_k | m_nn_kl;
	wire logic any_pos = m_pos | m_pos_l;
	wire logic any_npos = m_npos | m_npos_l;

	assign dec_o.valid = any_neg | any_nn | any_pos | any_npos;
	assign dec_o.likely = m_pos_l | m_npos_l | m_neg_l | m_neg_kl
		| m_nn_l | m_nn_kl;
	assign dec_o.link = m_neg_k | m_neg_kl | m_nn_k | m_nn_kl;
	assign dec_o.cond = any_neg ? ZCBU_COND_NEG :
		any_nn ? ZCBU_COND_NONNEG :
		any_pos ? ZCBU_COND_POS : ZCBU_COND_NONPOS;
endmodule // zcbu_decode
`default_nettype wire

// [verilog/zcbu_top.sv]
// branch resolution for the compare-against-zero branch family
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RQ1 - target is slot address plus offset times four
// RQ2 - taken branch runs exactly one delay slot
// RQ3 - untaken likely branch cancels its delay slot
// RQ4 - link forms always write branch address plus 8
// RQ5 - link with source r31 is not trapped
// RQ6 - nonneg forms take when sign bit clear
// RQ7 - positive forms need sign clear and nonzero
// RQ8 - nonpositive forms take on sign set or zero
// RQ9 - negative forms take when sign bit set
// RQ10 - evaluate in branch cycle, redirect next cycle
// RQ11 - decode by opcode and second register field
module zcbu_top (
	input wire logic CLK_SYS_I,
	input wire logic RESETN_I,
	input wire logic INSN_VALID_I,
	input wire logic [31:0] INSN_I,
	input wire logic [zcbu_pkg::XLEN-1:0] PC_I,
	input wire logic [zcbu_pkg::XLEN-1:0] SRC_VAL_I,
	input wire logic MODE64_I,
	output zcbu_pkg::zcbu_redir_t REDIR_O,
	output logic SLOT_CANCEL_O,
	output zcbu_pkg::zcbu_wb_t LINK_WB_O,
	output logic BRANCH_O,
	output logic TAKEN_O
);
	import zcbu_pkg::*;

	// -----------------------------------------------------------------
	// decode
	// -----------------------------------------------------------------
	zcbu_dec_t dec;

	zcbu_decode zcbu_decode_i (
		.insn_i(INSN_I),
		.dec_o(dec)
	);

	// a new branch is accepted only outside the previous branch's shadow
	logic shadow_q;
	wire logic br_go = INSN_VALID_I && dec.valid && !shadow_q;

	// -----------------------------------------------------------------
	// target arithmetic
	// -----------------------------------------------------------------
	wire logic [15:0] offset = INSN_I[OFF_HI:OFF_LO];
	// sign-extend to full width, then scale to a word offset
	wire logic [XLEN-1:0] off_ext = {{(XLEN-16){offset[15]}}, offset};
	wire logic [XLEN-1:0] off_scl = off_ext << OFF_SHIFT; // RQ1
	wire logic [XLEN-1:0] slot_pc = PC_I + XLEN'(SLOT_OFFSET);
	wire logic [XLEN-1:0] tgt64 = slot_pc + off_scl; // RQ1
	// 32-bit mode keeps the sign-extended low word
	wire logic [XLEN-1:0] tgt = MODE64_I ? tgt64 :
		{{(XLEN-32){tgt64[31]}}, tgt64[31:0]}; // RQ1
	wire logic [XLEN-1:0] link64 = PC_I + XLEN'(LINK_OFFSET); // RQ4
	wire logic [XLEN-1:0] link_val = MODE64_I ? link64 :
		{{(XLEN-32){link64[31]}}, link64[31:0]}; // RQ4

	// -----------------------------------------------------------------
	// condition evaluation
	// -----------------------------------------------------------------
	// sign bit follows the current operating width
	wire logic sign = MODE64_I ? SRC_VAL_I[63] : SRC_VAL_I[31]; // RQ6
	// zero test covers every bit of the current width
	wire logic is_zero = MODE64_I ? (SRC_VAL_I == '0) :
		(SRC_VAL_I[31:0] == 32'h0000_0000); // RQ8
	logic cond;

	// one condition per class, selected by the decoded form
	always_comb begin
		case (dec.cond)
			ZCBU_COND_NEG: cond = sign; // RQ9
			ZCBU_COND_NONNEG: cond = !sign; // RQ6
			ZCBU_COND_POS: cond = !sign && !is_zero; // RQ7
			ZCBU_COND_NONPOS: cond = sign || is_zero; // RQ8
			default: cond = 1'b0;
		endcase
	end

	// r31 as source is neither checked nor trapped here
	wire logic take = br_go && cond; // RQ5

	// -----------------------------------------------------------------
	// branch-cycle outputs (link write, status)
	// -----------------------------------------------------------------
	zcbu_wb_t wb_d;
	assign wb_d.valid = br_go && dec.link; // RQ4
	assign wb_d.index = LINK_REG;
	assign wb_d.data = link_val;

	// link is registered in the branch cycle, regardless of outcome
	always_ff @(posedge CLK_SYS_I) begin
		if (!RESETN_I) begin
			LINK_WB_O <= '0;
		end else begin
			LINK_WB_O <= wb_d; // RQ4 RQ10
		end
	end

	// shadow marks the delay-slot cycle after any accepted branch
	always_ff @(posedge CLK_SYS_I) begin
		if (!RESETN_I) begin
			shadow_q <= 1'b0;
			BRANCH_O <= 1'b0;
			TAKEN_O <= 1'b0;
		end else begin
			shadow_q <= br_go; // RQ2
			BRANCH_O <= br_go;
			TAKEN_O <= take;
		end
	end

	// -----------------------------------------------------------------
	// pc redirect and slot cancel, one cycle after the branch
	// -----------------------------------------------------------------
	zcbu_redir_t redir_d;
	assign redir_d.valid = take; // RQ2
	assign redir_d.target = tgt; // RQ1
	// only likely forms nullify, and only when not taken
	wire logic cancel_d = br_go && dec.likely && !cond; // RQ3

	// fetch sees the target in the slot cycle, so slot runs once
	always_ff @(posedge CLK_SYS_I) begin
		if (!RESETN_I) begin
			REDIR_O <= '0;
			SLOT_CANCEL_O <= 1'b0;
		end else begin
			REDIR_O <= redir_d; // RQ10
			SLOT_CANCEL_O <= cancel_d; // RQ3
		end
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	sequence s_branch_taken;
		br_go && cond;
	endsequence

	property p_redirect;
		@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		s_branch_taken |=> REDIR_O.valid && REDIR_O.target == $past(tgt);
	endproperty

	a_redirect_next_cycle: assert property (p_redirect) // RQ10
		else $error("taken branch did not redirect next cycle");

	a_target_value: assert property (@(posedge CLK_SYS_I) // RQ1
		disable iff (!RESETN_I)
		REDIR_O.valid && MODE64_I == $past(MODE64_I) && MODE64_I |->
		REDIR_O.target == $past(PC_I) + 64'h4
		+ ($past(off_ext) << 2))
		else $error("branch target mismatch");

	a_single_slot: assert property (@(posedge CLK_SYS_I) // RQ2
		disable iff (!RESETN_I)
		REDIR_O.valid |-> !$past(REDIR_O.valid))
		else $error("two redirects back to back");

	// a branch word in the delay slot must raise no branch, link write or slot cancel
	a_slot_ignored: assert property (@(posedge CLK_SYS_I) // RQ2
		disable iff (!RESETN_I)
		shadow_q |=> !BRANCH_O && !LINK_WB_O.valid && !SLOT_CANCEL_O)
		else $error("branch in delay slot was accepted");

	a_likely_cancel: assert property (@(posedge CLK_SYS_I) // RQ3
		disable iff (!RESETN_I)
		br_go && dec.likely && !cond |=> SLOT_CANCEL_O
		&& !REDIR_O.valid)
		else $error("untaken likely slot not cancelled");

	a_cancel_cause: assert property (@(posedge CLK_SYS_I) // RQ3
		disable iff (!RESETN_I)
		SLOT_CANCEL_O |-> $past(dec.likely) && !TAKEN_O)
		else $error("slot cancelled without cause");

	a_link_always: assert property (@(posedge CLK_SYS_I) // RQ4
		disable iff (!RESETN_I)
		br_go && dec.link |=> LINK_WB_O.valid
		&& LINK_WB_O.index == 5'h1f)
		else $error("link write missing");

	// return address must skip the slot, in 64-bit mode at least
	a_link_data: assert property (@(posedge CLK_SYS_I) // RQ4
		disable iff (!RESETN_I)
		br_go && dec.link && MODE64_I |=>
		LINK_WB_O.data == $past(PC_I) + 64'h8)
		else $error("link data wrong");

	a_link_r31_notrap: assert property (@(posedge CLK_SYS_I) // RQ5
		disable iff (!RESETN_I)
		br_go && dec.link && INSN_I[SRC_HI:SRC_LO] == 5'h1f
		|=> BRANCH_O)
		else $error("link branch on r31 not accepted");

	a_nonneg_sign: assert property (@(posedge CLK_SYS_I) // RQ6
		disable iff (!RESETN_I)
		br_go && dec.cond == ZCBU_COND_NONNEG |=>
		TAKEN_O == !$past(sign))
		else $error("nonneg condition wrong");

	a_pos_nonzero: assert property (@(posedge CLK_SYS_I) // RQ7
		disable iff (!RESETN_I)
		br_go && dec.cond == ZCBU_COND_POS && is_zero |=> !TAKEN_O)
		else $error("positive branch taken on zero");

	a_nonpos_zero: assert property (@(posedge CLK_SYS_I) // RQ8
		disable iff (!RESETN_I)
		br_go && dec.cond == ZCBU_COND_NONPOS && is_zero
		|=> TAKEN_O)
		else $error("nonpositive branch not taken on zero");

	a_neg_sign: assert property (@(posedge CLK_SYS_I) // RQ9
		disable iff (!RESETN_I)
		br_go && dec.cond == ZCBU_COND_NEG |=>
		TAKEN_O == $past(sign))
		else $error("negative condition wrong");

	a_decode_group: assert property (@(posedge CLK_SYS_I) // RQ11
		disable iff (!RESETN_I)
		dec.valid && INSN_I[OPC_HI:OPC_LO] != OPC_REG_IMM |->
		INSN_I[SEL_HI:SEL_LO] == 5'h00)
		else $error("decoded with nonzero second field");
endmodule // zcbu_top
`default_nettype wire

// [sim/zcbu_fetch_model.sv]
// fetch-side partner model: follows redirects, holds the link register
`timescale 1ns/1ps
`default_nettype none
module zcbu_fetch_model (
	input wire logic clk_i,
	input wire zcbu_pkg::zcbu_redir_t redir_i,
	input wire zcbu_pkg::zcbu_wb_t wb_i,
	output logic [zcbu_pkg::XLEN-1:0] pc_o,
	output logic [zcbu_pkg::XLEN-1:0] r31_o
);
	import zcbu_pkg::*;
	// pc moves only on a redirect; only index 31 reaches the link copy
	always_ff @(posedge clk_i) begin
		if (redir_i.valid) begin
			pc_o <= redir_i.target;
		end
		if (wb_i.valid && wb_i.index == LINK_REG) begin
			r31_o <= wb_i.data;
		end
	end
endmodule // zcbu_fetch_model
`default_nettype wire

// [sim/zero_compare_branch_unit_test.sv]
// self-checking bench for the zero-compare branch unit
`timescale 1ns/1ps
`default_nettype none
module zero_compare_branch_unit_test;
	import zcbu_pkg::*;
	logic CLK_SYS_I = 0;
	logic RESETN_I = 0;
	logic INSN_VALID_I = 0;
	logic MODE64_I = 1;
	logic [31:0] INSN_I = '0;
	logic [XLEN-1:0] PC_I = '0;
	logic [XLEN-1:0] SRC_VAL_I = '0;
	logic [XLEN-1:0] m_pc;
	logic [XLEN-1:0] m_r31;
	zcbu_redir_t REDIR_O;
	zcbu_wb_t LINK_WB_O;
	logic SLOT_CANCEL_O;
	logic BRANCH_O;
	logic TAKEN_O;
	int fails = 0;
	int checked = 0;
	int cyc = 0;

	zcbu_top zcbu_top_i (.CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I),
		.INSN_VALID_I(INSN_VALID_I), .INSN_I(INSN_I), .PC_I(PC_I),
		.SRC_VAL_I(SRC_VAL_I), .MODE64_I(MODE64_I), .REDIR_O(REDIR_O),
		.SLOT_CANCEL_O(SLOT_CANCEL_O), .LINK_WB_O(LINK_WB_O),
		.BRANCH_O(BRANCH_O), .TAKEN_O(TAKEN_O));
	zcbu_fetch_model zcbu_fetch_model_i (.clk_i(CLK_SYS_I),
		.redir_i(REDIR_O), .wb_i(LINK_WB_O), .pc_o(m_pc), .r31_o(m_r31));

	// ---------------------------------------------------------------
	// clock, timeout and helpers
	// ---------------------------------------------------------------
	always #25 CLK_SYS_I = ~CLK_SYS_I;
	// whole run needs about 260 cycles; over ten times that means a hang
	always @(posedge CLK_SYS_I) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			complete_run();
		end
	end
	task chk(input logic [69:0] seen, input logic [69:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// 32-bit mode results are sign-extended from bit 31
	function automatic logic [63:0] sx(input logic m, input logic [63:0] v);
		return m ? v : {{32{v[31]}}, v[31:0]};
	endfunction
	// kind: 0 negative, 1 nonneg, 2 positive, 3 nonpositive
	function automatic logic hit(input logic m, input logic [1:0] k,
		input logic [63:0] v);
		logic s;
		logic z;
		s = m ? v[63] : v[31];
		z = m ? (v == 0) : (v[31:0] == 0);
		case (k)
		2'd0: return s;
		2'd1: return !s;
		2'd2: return !s && !z;
		default: return s || z;
		endcase
	endfunction
	// one request cycle; valid drops at the edge the answer shows
	task put(input logic [31:0] insn, input logic [63:0] pc, v,
		input logic m);
		INSN_VALID_I = 1;
		INSN_I = insn;
		PC_I = pc;
		SRC_VAL_I = v;
		MODE64_I = m;
		@(negedge CLK_SYS_I);
		INSN_VALID_I = 0;
	endtask
	task outs(input logic b, tk, cn, ln, input logic [63:0] tgt, lnk);
		chk({BRANCH_O, TAKEN_O, SLOT_CANCEL_O, REDIR_O.valid}, {b, tk, cn, tk});
		chk(LINK_WB_O.valid, ln);
		if (tk) chk(REDIR_O.target, tgt);
		if (ln) chk({LINK_WB_O.index, LINK_WB_O.data}, {LINK_REG, lnk});
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	// forms 0..7 register-immediate group, 8..11 primary opcodes
	task br(input int f, input logic [63:0] pc, v, input logic m,
		input logic [15:0] off);
		logic [5:0] opc;
		logic [4:0] sel;
		logic [1:0] k;
		logic lk;
		logic ln;
		logic tk;
		if (f < 8) begin
			opc = OPC_REG_IMM;
			sel = {f[2], 2'b00, f[1:0]};
			k = {1'b0, f[0]};
			lk = f[1];
			ln = f[2];
		end else begin
			opc = f[0] ? (f[1] ? OPC_POS_LIKELY : OPC_POS)
				: (f[1] ? OPC_NONPOS_LIKELY : OPC_NONPOS);
			sel = SEL_ZERO;
			k = f[0] ? 2'd2 : 2'd3;
			lk = f[1];
			ln = 1'b0;
		end
		tk = hit(m, k, v);
		put({opc, 5'h03, sel, off}, pc, v, m);
		outs(1, tk, lk && !tk, ln, sx(m, pc + 4 + {{46{off[15]}}, off, 2'b00}), sx(m, pc + 8));
		@(negedge CLK_SYS_I);
		outs(0, 0, 0, 0, 0, 0);
	endtask
	// every form, both modes, sign and zero edge values
	task t_forms();
		logic [63:0] vals[5];
		vals = '{64'h5, 64'h0, '1, 64'h1_0000_0000, 64'h8000_0000};
		for (int m = 0; m < 2; m++) begin
			for (int f = 0; f < 12; f++) begin
				foreach (vals[i]) begin
					br(f, 64'h7fff_fffc, vals[i], m[0], f[0] ? 16'h8001 : 16'h7fff);
				end
			end
		end
	endtask
	// link branch testing r31, then a branch sitting in its delay slot
	task t_slot();
		INSN_VALID_I = 1;
		INSN_I = {OPC_REG_IMM, LINK_REG, SEL_NONNEG_LINK, 16'h0010};
		PC_I = 64'h1000;
		SRC_VAL_I = 64'h0;
		MODE64_I = 1;
		@(negedge CLK_SYS_I);
		outs(1, 1, 0, 1, 64'h1044, 64'h1008);
		INSN_I = {OPC_POS, 5'h02, SEL_ZERO, 16'h0020};
		PC_I = 64'h1004;
		SRC_VAL_I = 64'h5;
		@(negedge CLK_SYS_I);
		INSN_VALID_I = 0;
		outs(0, 0, 0, 0, 0, 0);
		chk(m_pc, 64'h1044);
		chk(m_r31, 64'h1008);
		// let valid stay low for a full cycle before the next scenario
		@(negedge CLK_SYS_I);
	endtask
	// words outside the family give nothing
	task t_refuse();
		logic [31:0] w[3];
		w = '{{6'h04, 5'h1, 5'h0, 16'h1}, {OPC_REG_IMM, 5'h1, 5'h04, 16'h1},
			{OPC_POS, 5'h1, 5'h01, 16'h1}};
		foreach (w[i]) begin
			put(w[i], 64'h2000, 64'h5, 1);
			outs(0, 0, 0, 0, 0, 0);
			@(negedge CLK_SYS_I);
		end
	endtask

	// ---------------------------------------------------------------
	// main sequence and verdict
	// ---------------------------------------------------------------
	task complete_run();
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge CLK_SYS_I);
		RESETN_I = 1;
		@(negedge CLK_SYS_I);
		t_forms();
		t_slot();
		t_refuse();
		complete_run();
	end
endmodule // zero_compare_branch_unit_test
`default_nettype wire
